// ==== sdcb_core.sv ====
// SDRAM command, mode, bank, refresh and burst data core with APB status
//
// Functional notes
// - All three strobes low loads the mode register from the address pins.
// - Mode holds burst length, ordering, latency two or three, and write mode.
// - Row strobe low, others high activates the addressed row of the bank.
// - Column command waits the row-to-column delay; write enable picks read or write. The core runs an early one at once and only sets err[0].
// - Column command gives first column; bursts 1,2,4,8,page wrap in aligned block.
// - Interleave beats are the start column xor an incrementing count.
// - Full page bursts use sequential order only.
// - A full page burst wraps in the page until another command ends it.
// - A new column command cuts the running burst and starts a full new one.
// - An internal counter supplies row and bank for refresh.
// - Chip select high leaves only clock, clock enable and byte masks effective.
// - Activate uses all eleven address bits; column uses low bits, top bit auto-precharges.
// - Precharge with top address bit high closes all banks, else the selected one.
// - An active byte mask blocks write data and floats read data of its lane.
// - Row and column strobes low with write enable high starts auto refresh.
// - Row strobe and write enable low, column strobe high is a precharge.
// - A read byte mask floats that lane two clocks later.
//
// The implementer's own choices: the address map and the APB slave port.
`timescale 1ns/10ps
`include "sdcb_params.svh"
module sdcb_core
   import sdcb_pkg::*;
#(
   parameter int COL_W = 8,
   parameter int ROW_W = 2
) (
   input  logic        ref_clk,            // 250 MHz system clock
   input  logic        reset_n,            // Asynchronous reset, active low
   input  logic        psel,               // APB select
   input  logic        penable,            // APB access phase
   input  logic        pwrite,             // APB write
   input  logic [11:0] paddr,              // APB byte address
   input  logic [31:0] pwdata,             // APB write data
   output logic [31:0] prdata,             // APB read data
   output logic        pready,             // APB ready
   output logic        pslverr,            // APB error, unmapped address
   input  sdcb_pins_s  pins,               // Command and address pins
   input  logic [3:0]  byte_lane_mask_bit, // Byte masks, active high
   input  logic [31:0] data_bus_in,        // Data bus level seen
   output logic [31:0] data_bus_out,       // Data bus drive value
   output logic [3:0]  data_bus_oe         // Per lane drive enable
);
   localparam int IDX_W = 2 + ROW_W + COL_W;

   if (COL_W < 3 || COL_W > 10 || ROW_W < 1 || IDX_W > 16) begin : g_bad
      $error("sdcb_core: COL_W or ROW_W out of range");
   end

   logic      rst_sync1, rst_n_sync;
   sdcb_cmd_e cmd;
   logic      col_cmd, is_stop, beat_valid, beat_is_write, ap_close;
   logic [COL_W-1:0] beat_col;
   logic [1:0] beat_bank;
   logic [IDX_W-1:0] mem_idx;
   logic [31:0] mem [2**IDX_W];
   wire  [3:0] open_vec;

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_sync1  <= 1'h0;
         rst_n_sync <= 1'h0;
      end else begin
         rst_sync1  <= 1'h1;
         rst_n_sync <= rst_sync1;
      end
   end

   sdcb_cmd_decode u_decode (
      .pins (pins),
      .cmd  (cmd)
   );

   // Mode register, refresh counter and initialisation progress
   sdcb_mode_s mode, next_mode;
   logic       mode_done, next_mode_done;
   logic [12:0] ref_addr, next_ref_addr;
   logic [3:0] init_refs, next_init_refs;

   always_comb begin
      next_mode      = mode;
      next_mode_done = mode_done;
      next_ref_addr  = ref_addr;
      next_init_refs = init_refs;
      if (cmd == CMD_MODE_SET) begin
         next_mode      = sdcb_mode_s'(pins.addr);
         next_mode_done = 1'h1;
      end
      if (cmd == CMD_REFRESH) begin
         // Bank in the top two bits, row below: no bank pins are used
         next_ref_addr = ref_addr + 13'h0001;
         if (init_refs != `SDCB_INIT_REF_MIN) begin
            next_init_refs = init_refs + 4'h1;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         mode      <= sdcb_mode_s'(`SDCB_MODE_RST);
         mode_done <= 1'h0;
         ref_addr  <= 13'h0000;
         init_refs <= 4'h0;
      end else begin
         mode      <= next_mode;
         mode_done <= next_mode_done;
         ref_addr  <= next_ref_addr;
         init_refs <= next_init_refs;
      end
   end

   // Burst context
   logic       burst_write, ap_pending, next_burst_write, next_ap_pending;
   logic [1:0] burst_bank, next_burst_bank;

   assign col_cmd = (cmd == CMD_READ) || (cmd == CMD_WRITE);
   assign is_stop = (cmd == CMD_BURST_STOP) || (cmd == CMD_PRECHARGE);

   sdcb_burst_gen #(
      .COL_W (COL_W)
   ) u_burst (
      .ref_clk    (ref_clk),
      .rst_n      (rst_n_sync),
      .load       (col_cmd),
      .stop       (is_stop),
      .start_col  (pins.addr[COL_W-1:0]),
      .len_code   (mode.burst_len),
      .interleave (mode.interleave),
      .single     ((cmd == CMD_WRITE) && mode.op_single_write),
      .beat_valid (beat_valid),
      .beat_col   (beat_col)
   );

   always_comb begin
      next_burst_write = burst_write;
      next_burst_bank  = burst_bank;
      next_ap_pending  = ap_pending;
      ap_close         = ap_pending && !beat_valid;
      if (col_cmd) begin
         next_burst_write = (cmd == CMD_WRITE);
         next_burst_bank  = pins.bank_select;
         next_ap_pending  = pins.addr[`SDCB_PRE_ALL_BIT];
      end else if (ap_close) begin
         next_ap_pending  = 1'h0;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         burst_write <= 1'h0;
         burst_bank  <= 2'h0;
         ap_pending  <= 1'h0;
      end else begin
         burst_write <= next_burst_write;
         burst_bank  <= next_burst_bank;
         ap_pending  <= next_ap_pending;
      end
   end

   // Per bank open state, open row and cycles since activate
   logic        bank_open [4];
   logic [10:0] open_row  [4];
   logic [3:0]  rcd_cnt   [4];

   for (genvar b = 0; b < 4; b++) begin : g_bank
      logic        next_open;
      logic [10:0] next_row;
      logic [3:0]  next_rcd;
      always_comb begin
         next_open = bank_open[b];
         next_row  = open_row[b];
         next_rcd  = (rcd_cnt[b] == 4'hF) ? rcd_cnt[b] : rcd_cnt[b] + 4'h1;
         if (cmd == CMD_ACTIVATE && pins.bank_select == 2'(b)) begin
            next_open = 1'h1;
            next_row  = pins.addr;
            next_rcd  = 4'h0;
         end
         if (cmd == CMD_PRECHARGE && (pins.addr[`SDCB_PRE_ALL_BIT] ||
             pins.bank_select == 2'(b))) begin
            next_open = 1'h0;
         end
         if (ap_close && burst_bank == 2'(b)) begin
            next_open = 1'h0;
         end
      end
      always_ff @(posedge ref_clk or negedge rst_n_sync) begin
         if (!rst_n_sync) begin
            bank_open[b] <= 1'h0;
            open_row[b]  <= 11'h000;
            rcd_cnt[b]   <= 4'hF;
         end else begin
            bank_open[b] <= next_open;
            open_row[b]  <= next_row;
            rcd_cnt[b]   <= next_rcd;
         end
      end
      assign open_vec[b] = bank_open[b];
   end

   // Data path; the array keeps only the low row bits, so rows alias
   logic [31:0] rd1, rd2, next_rd1, next_rd2, next_out;
   logic        v1, v2, next_v1, next_v2, cl2;
   logic [3:0]  m1, next_oe;

   assign beat_bank     = col_cmd ? pins.bank_select : burst_bank;
   assign beat_is_write = col_cmd ? (cmd == CMD_WRITE) : burst_write;
   assign mem_idx       = {beat_bank, open_row[beat_bank][ROW_W-1:0], beat_col};
   assign cl2           = (mode.cas_latency == `SDCB_CL2);

   always_ff @(posedge ref_clk) begin
      if (beat_valid && beat_is_write) begin
         for (int l = 0; l < 4; l++) begin
            if (!byte_lane_mask_bit[l]) begin
               mem[mem_idx][8*l +: 8] <= data_bus_in[8*l +: 8];
            end
         end
      end
   end

   always_comb begin
      next_rd1 = mem[mem_idx];
      next_v1  = beat_valid && !beat_is_write;
      next_rd2 = rd1;
      next_v2  = v1;
      next_out = cl2 ? rd1 : rd2;
      // Mask sampled one clock ago gates the drive of the next clock
      next_oe  = {4{cl2 ? v1 : v2}} & ~m1;
   end

   always_ff @(posedge ref_clk or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         rd1          <= 32'h0000_0000;
         rd2          <= 32'h0000_0000;
         v1           <= 1'h0;
         v2           <= 1'h0;
         m1           <= 4'hF;
         data_bus_out <= 32'h0000_0000;
         data_bus_oe  <= 4'h0;
      end else begin
         rd1          <= next_rd1;
         rd2          <= next_rd2;
         v1           <= next_v1;
         v2           <= next_v2;
         m1           <= byte_lane_mask_bit;
         data_bus_out <= next_out;
         data_bus_oe  <= next_oe;
      end
   end

   // Protocol error flags: hardware set wins over a clear in the same cycle
   logic [3:0] err, err_set, err_clr, next_err;
   logic       apb_setup, apb_wr, hit;
   logic [3:0] ctrl_rcd, next_ctrl_rcd;
   logic [31:0] rd_val, next_prdata;
   logic       next_slverr;

   assign apb_setup = psel && !penable;
   assign apb_wr    = psel && penable && pwrite;
   assign pready    = psel && penable;

   always_comb begin
      err_set[0] = col_cmd && bank_open[pins.bank_select] &&
                   (rcd_cnt[pins.bank_select] < ctrl_rcd);
      err_set[1] = col_cmd && !bank_open[pins.bank_select];
      err_set[2] = (cmd == CMD_ACTIVATE) && !mode_done;
      err_set[3] = (cmd == CMD_MODE_SET) && (open_vec != 4'h0);
      err_clr    = (apb_wr && paddr == `SDCB_ERR_OFS) ? pwdata[3:0] : 4'h0;
      next_err   = (err & ~err_clr) | err_set;
      next_ctrl_rcd = ctrl_rcd;
      if (apb_wr && paddr == `SDCB_CTRL_OFS) begin
         next_ctrl_rcd = pwdata[3:0];
      end
      hit = 1'h1;
      case (paddr)
         `SDCB_CTRL_OFS:    rd_val = {28'h000_0000, ctrl_rcd};
         `SDCB_STATUS_OFS:  rd_val = {20'h0_0000, init_refs, open_vec, 1'h0,
                             mode_done && init_refs == `SDCB_INIT_REF_MIN,
                             beat_valid, mode_done};
         `SDCB_MODE_OFS:    rd_val = {21'h00_0000, mode};
         `SDCB_ERR_OFS:     rd_val = {28'h000_0000, err};
         `SDCB_REFRESH_OFS: rd_val = {19'h0_0000, ref_addr};
         default: begin
            rd_val = 32'h0000_0000;
            hit    = 1'h0;
         end
      endcase
      next_prdata = apb_setup ? rd_val : prdata;
      next_slverr = apb_setup ? !hit : pslverr;
   end

   always_ff @(posedge ref_clk or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         err      <= 4'h0;
         ctrl_rcd <= `SDCB_RCD_RST;
         prdata   <= 32'h0000_0000;
         pslverr  <= 1'h0;
      end else begin
         err      <= next_err;
         ctrl_rcd <= next_ctrl_rcd;
         prdata   <= next_prdata;
         pslverr  <= next_slverr;
      end
   end

   logic restart;
   assign restart = col_cmd || is_stop;

   AST_MODE_LOAD: assert property (@(posedge ref_clk) disable iff (!rst_n_sync)
      cmd == CMD_MODE_SET |=> mode == $past(pins.addr) && mode_done)
      else $error("mode register not loaded from address");
   AST_ACT_OPEN: assert property (@(posedge ref_clk) disable iff (!rst_n_sync)
      cmd == CMD_ACTIVATE |=> open_vec[$past(pins.bank_select)])
      else $error("activated bank not open");
   AST_PRE_ALL: assert property (@(posedge ref_clk) disable iff (!rst_n_sync)
      cmd == CMD_PRECHARGE && pins.addr[`SDCB_PRE_ALL_BIT] |=> open_vec == 4'h0)
      else $error("precharge all left a bank open");
   AST_PRE_ONE: assert property (@(posedge ref_clk) disable iff (!rst_n_sync)
      cmd == CMD_PRECHARGE && !pins.addr[`SDCB_PRE_ALL_BIT] |=>
      !open_vec[$past(pins.bank_select)])
      else $error("precharged bank still open");
   AST_REF_ADV: assert property (@(posedge ref_clk) disable iff (!rst_n_sync)
      cmd == CMD_REFRESH |=> ref_addr == $past(ref_addr) + 13'h0001)
      else $error("refresh counter did not advance");
   AST_IDLE_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_n_sync)
      (cmd == CMD_DESELECT || cmd == NO_OPERATION_CMD) && !ap_close |=>
      $stable(open_vec) && $stable(mode) && $stable(ref_addr))
      else $error("idle cycle changed state");
   AST_MASK_HIZ: assert property (@(posedge ref_clk) disable iff (!rst_n_sync)
      byte_lane_mask_bit[0] |-> ##2 !data_bus_oe[0])
      else $error("masked lane still driven two clocks later");
   AST_RCD_FLAG: assert property (@(posedge ref_clk) disable iff (!rst_n_sync)
      col_cmd && bank_open[pins.bank_select] &&
      rcd_cnt[pins.bank_select] < ctrl_rcd |=> err[0])
      else $error("early column command not flagged");
   AST_BL4_END: assert property (@(posedge ref_clk) disable iff (!rst_n_sync)
      (cmd == CMD_READ && mode.burst_len == `SDCB_BL4) ##1
      (beat_valid && !restart)[*3] |=> !beat_valid || col_cmd)
      else $error("four beat burst ran past four beats");
endmodule : sdcb_core

// ==== sdcb_params.svh ====
// Offsets, reset values, field codes and counts of the command/burst core
`ifndef SDCB_PARAMS_SVH
`define SDCB_PARAMS_SVH
`define SDCB_CTRL_OFS     12'h000
`define SDCB_STATUS_OFS   12'h004
`define SDCB_MODE_OFS     12'h008
`define SDCB_ERR_OFS      12'h00C
`define SDCB_REFRESH_OFS  12'h010
`define SDCB_RCD_RST      4'h3
`define SDCB_MODE_RST     11'h000
`define SDCB_INIT_REF_MIN 4'h8
`define SDCB_BL1          3'h0
`define SDCB_BL2          3'h1
`define SDCB_BL4          3'h2
`define SDCB_BL8          3'h3
`define SDCB_BL_FULL      3'h7
`define SDCB_CL2          3'h2
`define SDCB_PRE_ALL_BIT  10
`endif

// ==== sdcb_pkg.sv ====
// Types shared by the command/burst core files
package sdcb_pkg;
   typedef enum logic [3:0] {
      CMD_SUSPENDED,
      CMD_DESELECT,
      NO_OPERATION_CMD,
      CMD_MODE_SET,
      CMD_REFRESH,
      CMD_PRECHARGE,
      CMD_ACTIVATE,
      CMD_WRITE,
      CMD_READ,
      CMD_BURST_STOP
   } sdcb_cmd_e;

   typedef struct packed {
      logic       cs_n;
      logic       ras_n;
      logic       cas_n;
      logic       we_n;
      logic       clk_en;
      logic [1:0] bank_select;
      logic [10:0] addr;
   } sdcb_pins_s;

   typedef struct packed {
      logic       rsvd_hi;
      logic       op_single_write;
      logic [1:0] rsvd_mid;
      logic [2:0] cas_latency;
      logic       interleave;
      logic [2:0] burst_len;
   } sdcb_mode_s;
endpackage : sdcb_pkg

// ==== sdcb_cmd_decode.sv ====
// Command decoder for the strobe pins
`timescale 1ns/10ps
module sdcb_cmd_decode
   import sdcb_pkg::*;
(
   input  sdcb_pins_s pins,  // Sampled command pins
   output sdcb_cmd_e  cmd    // Decoded command
);
   always_comb begin
      // A low clock enable only drops the command; suspend is not modelled
      if (!pins.clk_en) begin
         cmd = CMD_SUSPENDED;
      end else if (pins.cs_n) begin
         cmd = CMD_DESELECT;
      end else begin
         case ({pins.ras_n, pins.cas_n, pins.we_n})
            3'h0:    cmd = CMD_MODE_SET;
            3'h1:    cmd = CMD_REFRESH;
            3'h2:    cmd = CMD_PRECHARGE;
            3'h3:    cmd = CMD_ACTIVATE;
            3'h4:    cmd = CMD_WRITE;
            3'h5:    cmd = CMD_READ;
            3'h6:    cmd = CMD_BURST_STOP;
            default: cmd = NO_OPERATION_CMD;
         endcase
      end
   end
endmodule : sdcb_cmd_decode

// ==== sdcb_burst_gen.sv ====
// Burst column address sequencer
`timescale 1ns/10ps
`include "sdcb_params.svh"
module sdcb_burst_gen
   import sdcb_pkg::*;
#(
   parameter int COL_W = 8
) (
   input  logic             ref_clk,     // System clock
   input  logic             rst_n,       // Synchronised reset, active low
   input  logic             load,        // Column command this cycle
   input  logic             stop,        // Terminate the running burst
   input  logic [COL_W-1:0] start_col,   // First column of a new burst
   input  logic [2:0]       len_code,    // Burst length field
   input  logic             interleave,  // Interleave order requested
   input  logic             single,      // Force a burst of one
   output logic             beat_valid,  // A beat is addressed this cycle
   output logic [COL_W-1:0] beat_col     // Column of the current beat
);
   logic [COL_W-1:0] start_q, mask_q, cnt_q, ld_mask;
   logic [COL_W-1:0] next_start, next_mask, next_cnt;
   logic             active, il_q, full_q, ld_full;
   logic             next_active, next_il, next_full;

   function automatic logic [COL_W-1:0] beat_of(
      input logic [COL_W-1:0] s,
      input logic [COL_W-1:0] m,
      input logic [COL_W-1:0] c,
      input logic             il);
      beat_of = il ? (s ^ c) : ((s & ~m) | ((s + c) & m));
   endfunction : beat_of

   always_comb begin
      ld_full = (len_code == `SDCB_BL_FULL) && !single;
      case (len_code)
         `SDCB_BL2:     ld_mask = COL_W'(1);
         `SDCB_BL4:     ld_mask = COL_W'(3);
         `SDCB_BL8:     ld_mask = COL_W'(7);
         `SDCB_BL_FULL: ld_mask = '1;
         default:       ld_mask = '0;
      endcase
      if (single) begin
         ld_mask = '0;
      end
      next_start  = start_q;
      next_mask   = mask_q;
      next_cnt    = cnt_q;
      next_il     = il_q;
      next_full   = full_q;
      next_active = active;
      if (load) begin
         next_start  = start_col;
         next_mask   = ld_mask;
         next_il     = interleave && !ld_full;
         next_full   = ld_full;
         next_cnt    = COL_W'(1);
         next_active = (ld_mask != '0);
      end else if (stop) begin
         next_active = 1'h0;
      end else if (active) begin
         next_cnt    = cnt_q + COL_W'(1);
         next_active = full_q || (cnt_q != mask_q);
      end
      beat_valid = load || active;
      beat_col   = load ? start_col : beat_of(start_q, mask_q, cnt_q, il_q);
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         start_q <= '0;
         mask_q  <= '0;
         cnt_q   <= '0;
         il_q    <= 1'h0;
         full_q  <= 1'h0;
         active  <= 1'h0;
      end else begin
         start_q <= next_start;
         mask_q  <= next_mask;
         cnt_q   <= next_cnt;
         il_q    <= next_il;
         full_q  <= next_full;
         active  <= next_active;
      end
   end

   AST_INTLV_ORDER: assert property (@(posedge ref_clk) disable iff (!rst_n)
      active && il_q && !load |-> (beat_col ^ start_q) == cnt_q)
      else $error("interleave beat is not start xor count");
   AST_SEQ_WRAP: assert property (@(posedge ref_clk) disable iff (!rst_n)
      active && !il_q && !load |-> (beat_col & ~mask_q) == (start_q & ~mask_q))
      else $error("sequential beat left its aligned block");
   AST_FULL_RUN: assert property (@(posedge ref_clk) disable iff (!rst_n)
      active && full_q && !load && !stop |=> active)
      else $error("full page burst ended by itself");
   AST_RESTART: assert property (@(posedge ref_clk) disable iff (!rst_n)
      load |=> cnt_q == COL_W'(1) && start_q == $past(start_col))
      else $error("interrupting burst did not restart");
   AST_NO_FULL_IL: assert property (@(posedge ref_clk) disable iff (!rst_n)
      load && ld_full |=> !il_q && full_q)
      else $error("full page burst used interleave order");
endmodule : sdcb_burst_gen

// ==== sdcb_ctrl_model.sv ====
// Memory controller model: command pins, byte masks, data wire
`timescale 1ns/10ps
module sdcb_ctrl_model
   import sdcb_pkg::*;
(
   input  wire logic        ref_clk, // System clock
   input  wire logic [31:0] dq_out,  // Device drive value
   input  wire logic [3:0]  dq_oe,   // Device lane enables
   output sdcb_pins_s       pins,    // Command pins
   output logic [3:0]       mask,    // Byte masks
   output logic [31:0]      dq_in    // Resolved data wire
);
   logic [31:0] drv;
   initial begin
      pins = {5'h0F, 13'h0000};
      mask = 4'hF;
      drv  = 32'h0000_0000;
   end
   // Released lanes show the controller data, or the inverse of the device value when the controller data is zero, so a stale value never matches
   always_comb begin
      for (int l = 0; l < 4; l++) begin
         dq_in[8*l+:8] = dq_oe[l] ? dq_out[8*l+:8] :
                         (|drv) ? drv[8*l+:8] : ~dq_out[8*l+:8];
      end
   end
   task automatic cyc(input logic [2:0] c, input logic [1:0] ba,
                      input logic [10:0] a, input logic [31:0] d,
                      input logic [3:0] m, input logic s);
      @(posedge ref_clk);
      pins.cs_n        <= s;
      {pins.ras_n, pins.cas_n, pins.we_n} <= c;
      pins.bank_select <= ba;
      pins.addr        <= a;
      drv              <= d;
      mask             <= m;
   endtask : cyc
endmodule : sdcb_ctrl_model

// ==== tb.sv ====
// Self-checking bench for the command/burst core
`timescale 1ns/10ps
module tb;
   import sdcb_pkg::*;
   localparam logic [2:0] MSET = 3'h0, RFSH = 3'h1, PCHG = 3'h2;
   localparam logic [2:0] ACTV = 3'h3, WRT = 3'h4, RDT = 3'h5;
   localparam logic [2:0] IDLE = 3'h7, BSTP = 3'h6;
   localparam int         PAUSE = 50000;
   logic        ref_clk, reset_n, psel, penable, pwrite, pready, e;
   logic        pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, dq_out, dq_in, r;
   logic [3:0]  dq_oe, mask;
   sdcb_pins_s  pins;
   int          fail_count, n_compared, cycles;
   sdcb_core sdcb_core_inst (.ref_clk(ref_clk), .reset_n(reset_n),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pins(pins), .byte_lane_mask_bit(mask),
      .data_bus_in(dq_in), .data_bus_out(dq_out), .data_bus_oe(dq_oe));
   sdcb_ctrl_model sdcb_ctrl_model_inst (.ref_clk(ref_clk),
      .dq_out(dq_out), .dq_oe(dq_oe), .pins(pins), .mask(mask),
      .dq_in(dq_in));
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   task automatic chk(input string nm, input logic [31:0] s, x);
      n_compared++;
      if (s !== x) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", nm, x, s);
      end
   endtask : chk
   task automatic give_verdict();
      if (fail_count == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : give_verdict
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge ref_clk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do
         @(posedge ref_clk);
      while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic cy(input logic [2:0] c, input logic [1:0] ba,
                     input logic [10:0] a, input logic [31:0] d,
                     input logic [3:0] m = 4'h0, input logic s = 1'b0);
      sdcb_ctrl_model_inst.cyc(c, ba, a, d, m, s);
   endtask : cy
   function automatic logic [7:0] col(input logic [7:0] s, n, k,
                                      input logic il);
      return il ? s ^ k : (s & ~(n - 8'h01)) | ((s + k) & (n - 8'h01));
   endfunction : col
   task automatic wb(input logic [7:0] s, n, input logic il);
      for (int k = 0; k < n; k++) begin
         cy(k == 0 ? WRT : IDLE, 2'h1, {3'h0, s},
            {24'hC0_DE00, col(s, n, 8'(k), il)});
      end
      cy(IDLE, 2'h1, 11'h000, 32'h0000_0000);
   endtask : wb
   task automatic rb(input logic [7:0] s, n, input logic il);
      cy(RDT, 2'h1, {3'h0, s}, 32'h0000_0000);
      cy(IDLE, 2'h1, 11'h000, 32'h0000_0000);
      for (int k = 0; k < n; k++) begin
         @(posedge ref_clk);
         #1;
         chk("rd_data", dq_out,
             {24'hC0_DE00, col(s, n, 8'(k), il)});
         chk("rd_oe", {28'h0, dq_oe}, 32'h0000_000F);
      end
      @(posedge ref_clk);
      #1;
      chk("rd_end", {28'h0, dq_oe}, 32'h0000_0000);
   endtask : rb
   // Watchdog sized for the power-on pause plus the short traffic
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         fail_count++;
         give_verdict();
      end
   end
   initial begin
      reset_n = 1'b0;
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 12'h000;
      pwdata  = 32'h0000_0000;
      repeat (10) @(posedge ref_clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge ref_clk);
      apb(1'b0, 12'h000, 32'h0);
      chk("ctrl", r, 32'h0000_0003);
      apb(1'b0, 12'h014, 32'h0);
      chk("unmapped", {31'h0, e}, 32'h0000_0001);
      repeat (PAUSE) @(posedge ref_clk);
      cy(PCHG, 2'h0, 11'h400, 32'h0);
      repeat (8) cy(RFSH, 2'h0, 11'h000, 32'h0);
      cy(MSET, 2'h0, 11'h022, 32'h0);
      cy(IDLE, 2'h0, 11'h000, 32'h0);
      apb(1'b0, 12'h004, 32'h0);
      chk("status", r, 32'h0000_0805);
      apb(1'b0, 12'h008, 32'h0);
      chk("mode", r, 32'h0000_0022);
      cy(ACTV, 2'h1, 11'h005, 32'h0);
      repeat (3) cy(IDLE, 2'h1, 11'h000, 32'h0);
      wb(8'h02, 8'h04, 1'b0);
      rb(8'h00, 8'h04, 1'b0);
      cy(PCHG, 2'h0, 11'h400, 32'h0);
      cy(MSET, 2'h0, 11'h02B, 32'h0);
      cy(IDLE, 2'h0, 11'h000, 32'h0);
      cy(ACTV, 2'h1, 11'h005, 32'h0);
      repeat (3) cy(IDLE, 2'h1, 11'h000, 32'h0);
      wb(8'h00, 8'h08, 1'b1);
      rb(8'h02, 8'h08, 1'b1);
      // Write cuts a read; masks keep the fetched read beat off the bus
      cy(RDT, 2'h1, 11'h000, 32'h0);
      cy(IDLE, 2'h1, 11'h000, 32'h0, 4'hF);
      cy(WRT, 2'h1, 11'h000, 32'h5A5A_5A5A, 4'hF);
      #1;
      chk("rd_live", {28'h0, dq_oe}, 32'h0000_000F);
      cy(BSTP, 2'h1, 11'h000, 32'h0, 4'hF);
      #1;
      chk("rd_masked", {28'h0, dq_oe}, 32'h0000_0000);
      rb(8'h00, 8'h08, 1'b1);
      cy(ACTV, 2'h2, 11'h000, 32'h0);
      cy(RDT, 2'h2, 11'h000, 32'h0);
      repeat (12) cy(IDLE, 2'h2, 11'h000, 32'h0);
      apb(1'b0, 12'h00C, 32'h0);
      chk("err_early", r, 32'h0000_0001);
      apb(1'b1, 12'h00C, 32'h0000_0001);
      apb(1'b0, 12'h00C, 32'h0);
      chk("err_clear", r, 32'h0000_0000);
      cy(PCHG, 2'h2, 11'h000, 32'h0);
      cy(MSET, 2'h0, 11'h000, 32'h0, 4'h0, 1'b1);
      cy(IDLE, 2'h0, 11'h000, 32'h0);
      apb(1'b0, 12'h004, 32'h0);
      chk("pre_one", r, 32'h0000_0825);
      apb(1'b0, 12'h008, 32'h0);
      chk("deselect", r, 32'h0000_002B);
      apb(1'b0, 12'h010, 32'h0);
      chk("refresh", r, 32'h0000_0008);
      // Page length with interleave asked: must run sequential, no end
      cy(PCHG, 2'h0, 11'h400, 32'h0);
      cy(MSET, 2'h0, 11'h02F, 32'h0);
      cy(IDLE, 2'h0, 11'h000, 32'h0);
      cy(ACTV, 2'h1, 11'h005, 32'h0);
      repeat (3) cy(IDLE, 2'h1, 11'h000, 32'h0);
      cy(RDT, 2'h1, 11'h0FE, 32'h0);
      repeat (4) cy(IDLE, 2'h1, 11'h000, 32'h0);
      #1;
      chk("page_wrap", dq_out, 32'hC0DE_0000);
      repeat (8) cy(IDLE, 2'h1, 11'h000, 32'h0);
      #1;
      chk("page_run", {28'h0, dq_oe}, 32'h0000_000F);
      cy(BSTP, 2'h1, 11'h000, 32'h0);
      repeat (3) cy(IDLE, 2'h1, 11'h000, 32'h0);
      #1;
      chk("page_stop", {28'h0, dq_oe}, 32'h0000_0000);
      give_verdict();
   end
endmodule : tb
